// ### src/fwp_pkg.sv
package fwp_pkg;

  // opcodes
  localparam logic [7:0] OPC_SET_LATCH    = 8'h06;
  localparam logic [7:0] OPC_CLEAR_LATCH  = 8'h04;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_FUNC_WRITE   = 8'h42;
  localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
  localparam logic [7:0] OPC_FUNC_READ    = 8'h48;
  localparam logic [7:0] OPC_PARAM_SET    = 8'hC0;
  localparam logic [7:0] OPC_PARAM_READ   = 8'h61;
  localparam logic [7:0] OPC_PAGE_PROG    = 8'h02;
  localparam logic [7:0] OPC_QPROG_A      = 8'h32;
  localparam logic [7:0] OPC_QPROG_B      = 8'h38;
  localparam logic [7:0] OPC_SECT_ERASE_A = 8'hD7;
  localparam logic [7:0] OPC_SECT_ERASE_B = 8'h20;
  localparam logic [7:0] OPC_HALF_ERASE   = 8'h52;
  localparam logic [7:0] OPC_FULL_ERASE   = 8'hD8;
  localparam logic [7:0] OPC_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OPC_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OPC_IR_ERASE     = 8'h64;
  localparam logic [7:0] OPC_IR_PROG      = 8'h62;
  localparam logic [7:0] OPC_SUSPEND      = 8'h75;
  localparam logic [7:0] OPC_RESUME       = 8'h7A;

  // frame lengths in bits
  localparam logic [5:0] LEN_OPC  = 6'd8;
  localparam logic [5:0] LEN_DATA = 6'd16;
  localparam logic [5:0] LEN_ADDR = 6'd32;
  localparam logic [5:0] LEN_PROG = 6'd40;

  // status register fields
  localparam int ST_WRITE_IN_PROGRESS    = 0;
  localparam int ST_WRITE_ENABLE_LATCH   = 1;
  localparam int ST_BP_LO                = 2;
  localparam int ST_QUAD_ENABLE          = 6;
  localparam int ST_STATUS_WRITE_DISABLE = 7;
  // function register fields
  localparam int FN_TOP_BOTTOM_SELECT    = 1;
  localparam int FN_PROGRAM_SUSPENDED    = 2;
  localparam int FN_ERASE_SUSPENDED      = 3;
  localparam int FN_INFO_ROW_LOCK_LO     = 4;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] FUNC_RESET   = 8'h00;
  localparam logic [7:0] PARAM_RESET  = 8'hE0;

  localparam int BLOCK_MSB = 22;
  localparam int BLOCK_LSB = 16;
  localparam int IR_SEL_MSB = 13;
  localparam int IR_SEL_LSB = 12;
  localparam logic [7:0] NUM_BLOCKS = 8'h80;

  typedef enum logic [2:0] {
    ARR_NONE,
    ARR_PROGRAM,
    ARR_SECTOR_ERASE,
    ARR_HALF_ERASE,
    ARR_FULL_ERASE,
    ARR_CHIP_ERASE,
    ARR_IR_PROGRAM,
    ARR_IR_ERASE
  } fwp_arr_op_t;

  typedef struct packed {
    fwp_arr_op_t op;
    logic [23:0] addr;
  } fwp_req_t;

endpackage

// ### src/fwp_flash_write_protect_regs.sv
`timescale 1ns/1ps
// Functional notes
// - set-latch command sets the write latch
// - latch zero ignores gated write commands
// - read-parameter set needs no latch
// - page program opcodes need the latch
// - sector and block erase need the latch
// - clear-latch command clears the latch
// - latch clears when any write completes
// - no program/erase inside protected area
// - protection level decodes to block range
// - chip erase only with level zero
// - disable bit plus low pin locks status
// - status writable if bit zero or pin high
// - quad bit selects pin roles
// - function register bit layout, reset zero
// - one-time bits return to zero only on reset
// - program suspend flag set and cleared
// - erase suspend flag set and cleared
// - locked info row refuses program
// - status write clears the latch
// - status register bit layout, reset zero
// - busy bit high while operation runs
module fwp_flash_write_protect_regs
  import fwp_pkg::*;
(
  input  wire logic     REF_CLK,
  input  wire logic     RSTN,
  input  wire logic     SCK,
  input  wire logic     CE_N,
  input  wire logic     SI,
  input  wire logic     WP_N,
  input  wire logic     ARRAY_DONE,
  output logic          SO,
  output logic          SO_OE,
  output logic          ARRAY_START,
  output logic          ARRAY_SUSPEND,
  output logic          ARRAY_RESUME,
  output fwp_req_t      ARRAY_REQ,
  output logic          QUAD_DATA_MODE,
  output logic [7:0]    READ_PARAM
);

  function automatic logic fwp_is_protected(input logic [3:0] level,
                                            input logic       bottom,
                                            input logic [6:0] blk);
    logic [7:0] span;
    span = 8'h00;
    if (level == 4'h0)
      return 1'b0;
    if (level[3])
      return 1'b1;
    span = 8'h01 << (level[2:0] - 3'h1);
    if (bottom)
      return {1'b0, blk} < span;
    return {1'b0, blk} >= (NUM_BLOCKS - span);
  endfunction

  function automatic logic fwp_op_is_prog(input fwp_arr_op_t op);
    return (op == ARR_PROGRAM) || (op == ARR_IR_PROGRAM);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] sck_sync_reg;
  logic [2:0] ce_sync_reg;
  logic [1:0] si_sync_reg;
  logic [1:0] wp_sync_reg;

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sck_sync_reg <= 3'h0;
      ce_sync_reg  <= 3'h7;
      si_sync_reg  <= 2'h0;
      wp_sync_reg  <= 2'h3;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], SCK};
      ce_sync_reg  <= {ce_sync_reg[1:0], CE_N};
      si_sync_reg  <= {si_sync_reg[0], SI};
      wp_sync_reg  <= {wp_sync_reg[0], WP_N};
    end
  end

  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic frame_end;
  logic frame_start;
  logic wp_high;

  assign sel         = ~ce_sync_reg[1];
  assign sck_rise    = sel & sck_sync_reg[1] & ~sck_sync_reg[2];
  assign sck_fall    = sel & ~sck_sync_reg[1] & sck_sync_reg[2];
  assign frame_end   = ce_sync_reg[1] & ~ce_sync_reg[2];
  assign frame_start = ~ce_sync_reg[1] & ce_sync_reg[2];
  assign wp_high     = wp_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // frame capture

  logic [5:0]  bit_cnt_reg;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [7:0]  opc_reg;
  logic [7:0]  data_reg;
  logic [23:0] addr_reg;

  assign shift_next = {shift_reg[30:0], si_sync_reg[1]};

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      bit_cnt_reg <= 6'h00;
      shift_reg   <= 32'h0000_0000;
      opc_reg     <= 8'h00;
      data_reg    <= 8'h00;
      addr_reg    <= 24'h00_0000;
    end
    else if (frame_start)
    begin
      bit_cnt_reg <= 6'h00;
      opc_reg     <= 8'h00;
    end
    else if (sck_rise)
    begin
      shift_reg <= shift_next;
      if (bit_cnt_reg != 6'h3F)
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      if (bit_cnt_reg == LEN_OPC - 6'h01)
        opc_reg <= shift_next[7:0];
      if (bit_cnt_reg == LEN_DATA - 6'h01)
        data_reg <= shift_next[7:0];
      if (bit_cnt_reg == LEN_ADDR - 6'h01)
        addr_reg <= shift_next[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic        write_enable_latch_reg;
  logic        write_in_progress_reg;
  logic        status_write_disable_reg;
  logic        quad_enable_reg;
  logic [3:0]  bp_reg;
  logic [3:0]  info_row_lock_reg;
  logic        erase_suspended_flag_reg;
  logic        program_suspended_flag_reg;
  logic        top_bottom_select_reg;
  logic [7:0]  status_byte;
  logic [7:0]  func_byte;

  assign status_byte = {status_write_disable_reg, quad_enable_reg, bp_reg,
                        write_enable_latch_reg, write_in_progress_reg};
  assign func_byte   = {info_row_lock_reg, erase_suspended_flag_reg,
                        program_suspended_flag_reg, top_bottom_select_reg,
                        1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // command decode at frame end

  logic        wr_ok;
  logic        blk_prot;
  logic        suspended;
  fwp_arr_op_t start_op;
  logic        start_ok;
  logic        sr_write;
  logic        fr_write;
  logic        suspend_ok;
  logic        resume_ok;

  assign suspended = program_suspended_flag_reg | erase_suspended_flag_reg;
  assign wr_ok     = write_enable_latch_reg & ~write_in_progress_reg;
  assign blk_prot  = fwp_is_protected(bp_reg, top_bottom_select_reg,
                                      addr_reg[BLOCK_MSB:BLOCK_LSB]);

  always_comb
  begin
    start_op = ARR_NONE;
    case (opc_reg)
      OPC_PAGE_PROG, OPC_QPROG_A, OPC_QPROG_B:
        if (bit_cnt_reg >= LEN_PROG && !blk_prot)
          start_op = ARR_PROGRAM;
      OPC_SECT_ERASE_A, OPC_SECT_ERASE_B:
        if (bit_cnt_reg == LEN_ADDR && !blk_prot)
          start_op = ARR_SECTOR_ERASE;
      OPC_HALF_ERASE:
        if (bit_cnt_reg == LEN_ADDR && !blk_prot)
          start_op = ARR_HALF_ERASE;
      OPC_FULL_ERASE:
        if (bit_cnt_reg == LEN_ADDR && !blk_prot)
          start_op = ARR_FULL_ERASE;
      OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B:
        if (bit_cnt_reg == LEN_OPC && bp_reg == 4'h0)
          start_op = ARR_CHIP_ERASE;
      OPC_IR_PROG:
        if (bit_cnt_reg >= LEN_PROG
            && !info_row_lock_reg[addr_reg[IR_SEL_MSB:IR_SEL_LSB]])
          start_op = ARR_IR_PROGRAM;
      OPC_IR_ERASE:
        if (bit_cnt_reg == LEN_ADDR)
          start_op = ARR_IR_ERASE;
      default:
        start_op = ARR_NONE;
    endcase
  end

  assign start_ok   = frame_end & wr_ok & ~suspended & (start_op != ARR_NONE);
  assign sr_write   = frame_end & wr_ok & (opc_reg == OPC_STATUS_WRITE)
                      & (bit_cnt_reg >= LEN_DATA)
                      & (~status_write_disable_reg | wp_high);
  assign fr_write   = frame_end & wr_ok & (opc_reg == OPC_FUNC_WRITE)
                      & (bit_cnt_reg >= LEN_DATA);
  assign suspend_ok = frame_end & write_in_progress_reg & (opc_reg == OPC_SUSPEND)
                      & (bit_cnt_reg == LEN_OPC);
  assign resume_ok  = frame_end & ~write_in_progress_reg & suspended
                      & (opc_reg == OPC_RESUME)
                      & (bit_cnt_reg == LEN_OPC);

  ////////////////////////////////////////////////////////////////////////////
  // write latch and busy

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      write_enable_latch_reg <= 1'b0;
    else if (write_in_progress_reg && ARRAY_DONE)
      write_enable_latch_reg <= 1'b0;
    else if (sr_write || fr_write)
      write_enable_latch_reg <= 1'b0;
    else if (frame_end && bit_cnt_reg == LEN_OPC && opc_reg == OPC_SET_LATCH)
      write_enable_latch_reg <= 1'b1;
    else if (frame_end && bit_cnt_reg == LEN_OPC && opc_reg == OPC_CLEAR_LATCH)
      write_enable_latch_reg <= 1'b0;
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      write_in_progress_reg <= 1'b0;
      ARRAY_START   <= 1'b0;
      ARRAY_SUSPEND <= 1'b0;
      ARRAY_RESUME  <= 1'b0;
      ARRAY_REQ     <= '{op: ARR_NONE, addr: 24'h00_0000};
    end
    else
    begin
      ARRAY_START   <= start_ok;
      ARRAY_SUSPEND <= suspend_ok;
      ARRAY_RESUME  <= resume_ok;
      if (start_ok)
      begin
        write_in_progress_reg <= 1'b1;
        ARRAY_REQ             <= '{op: start_op, addr: addr_reg};
      end
      else if (resume_ok)
        write_in_progress_reg <= 1'b1;
      else if (suspend_ok || ARRAY_DONE)
        write_in_progress_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      status_write_disable_reg <= STATUS_RESET[ST_STATUS_WRITE_DISABLE];
      quad_enable_reg          <= STATUS_RESET[ST_QUAD_ENABLE];
      bp_reg                   <= STATUS_RESET[ST_BP_LO +: 4];
    end
    else if (sr_write)
    begin
      status_write_disable_reg <= data_reg[ST_STATUS_WRITE_DISABLE];
      quad_enable_reg          <= data_reg[ST_QUAD_ENABLE];
      bp_reg                   <= data_reg[ST_BP_LO +: 4];
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      QUAD_DATA_MODE <= STATUS_RESET[ST_QUAD_ENABLE];
    else
      QUAD_DATA_MODE <= quad_enable_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // function register

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      top_bottom_select_reg <= FUNC_RESET[FN_TOP_BOTTOM_SELECT];
      info_row_lock_reg     <= FUNC_RESET[FN_INFO_ROW_LOCK_LO +: 4];
    end
    else if (fr_write)
    begin
      top_bottom_select_reg <= top_bottom_select_reg
                               | data_reg[FN_TOP_BOTTOM_SELECT];
      info_row_lock_reg     <= info_row_lock_reg
                               | data_reg[FN_INFO_ROW_LOCK_LO +: 4];
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      program_suspended_flag_reg <= FUNC_RESET[FN_PROGRAM_SUSPENDED];
      erase_suspended_flag_reg   <= FUNC_RESET[FN_ERASE_SUSPENDED];
    end
    else if (suspend_ok)
    begin
      if (fwp_op_is_prog(ARRAY_REQ.op))
        program_suspended_flag_reg <= 1'b1;
      else
        erase_suspended_flag_reg <= 1'b1;
    end
    else if (resume_ok)
    begin
      program_suspended_flag_reg <= 1'b0;
      erase_suspended_flag_reg   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read parameters

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      READ_PARAM <= PARAM_RESET;
    else if (frame_end && opc_reg == OPC_PARAM_SET && bit_cnt_reg >= LEN_DATA)
      READ_PARAM <= data_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register readout, same byte repeats until deselect

  logic [7:0] out_shift_reg;
  logic       rd_active_reg;
  logic [7:0] rd_byte;
  logic       rd_hit;

  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (shift_next[7:0])
      OPC_STATUS_READ: rd_byte = status_byte;
      OPC_FUNC_READ:   rd_byte = func_byte;
      OPC_PARAM_READ:  rd_byte = READ_PARAM;
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      out_shift_reg <= 8'h00;
      rd_active_reg <= 1'b0;
      SO            <= 1'b0;
      SO_OE         <= 1'b0;
    end
    else if (!sel)
    begin
      rd_active_reg <= 1'b0;
      SO_OE         <= 1'b0;
    end
    else if (sck_rise && bit_cnt_reg == LEN_OPC - 6'h01)
    begin
      out_shift_reg <= rd_byte;
      rd_active_reg <= rd_hit;
    end
    else if (sck_fall && rd_active_reg)
    begin
      SO            <= out_shift_reg[7];
      SO_OE         <= 1'b1;
      out_shift_reg <= {out_shift_reg[6:0], out_shift_reg[7]};
    end
  end

endmodule

// ### bench/fwp_chk.sv
`timescale 1ns/1ps
module fwp_chk
  import fwp_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RSTN,
  input wire logic       CE_N,
  input wire logic       ARRAY_DONE,
  input wire logic       SO_OE,
  input wire logic       ARRAY_START,
  input wire logic       ARRAY_SUSPEND,
  input wire logic       ARRAY_RESUME,
  input wire fwp_req_t   ARRAY_REQ,
  input wire logic       QUAD_DATA_MODE,
  input wire logic [7:0] READ_PARAM
);
  logic act_reg;
  logic sus_reg;
  // an array operation is running or parked
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      act_reg <= 1'b0;
    else if (ARRAY_START)
      act_reg <= 1'b1;
    else if (ARRAY_DONE && !sus_reg)
      act_reg <= 1'b0;
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      sus_reg <= 1'b0;
    else if (ARRAY_SUSPEND)
      sus_reg <= 1'b1;
    else if (ARRAY_RESUME)
      sus_reg <= 1'b0;
  ////////////////////////////////////////
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  sequence s_frame_idle;
    CE_N [*6];
  endsequence
  sequence s_quiet;
    !ARRAY_START ##1 !ARRAY_START;
  endsequence
  a_start_idle: assert property (ARRAY_START |-> !act_reg)
    else $error("start while an operation runs");
  a_start_frame_end: assert property (ARRAY_START |-> CE_N)
    else $error("start inside a frame");
  a_req_holds: assert property (s_quiet |-> $stable(ARRAY_REQ))
    else $error("request changed without start");
  a_start_kind: assert property (ARRAY_START |=> ARRAY_REQ.op != ARR_NONE)
    else $error("start without operation kind");
  a_suspend_run: assert property (ARRAY_SUSPEND |-> act_reg && !sus_reg)
    else $error("suspend with nothing running");
  a_resume_parked: assert property (ARRAY_RESUME |-> sus_reg)
    else $error("resume with nothing suspended");
  a_quad_frame_end: assert property ($changed(QUAD_DATA_MODE) |-> CE_N)
    else $error("quad mode changed inside a frame");
  a_param_frame_end: assert property ($changed(READ_PARAM) |-> CE_N)
    else $error("read parameters changed inside a frame");
  a_so_released: assert property (s_frame_idle |-> !SO_OE)
    else $error("output still driven after frame");
endmodule
bind fwp_flash_write_protect_regs fwp_chk u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .CE_N(CE_N), .ARRAY_DONE(ARRAY_DONE), .SO_OE(SO_OE),
  .ARRAY_START(ARRAY_START), .ARRAY_SUSPEND(ARRAY_SUSPEND), .ARRAY_RESUME(ARRAY_RESUME),
  .ARRAY_REQ(ARRAY_REQ), .QUAD_DATA_MODE(QUAD_DATA_MODE), .READ_PARAM(READ_PARAM)
);

// ### bench/fwp_host_model.sv
`timescale 1ns/1ps
module fwp_host_model (
  output logic     sck,
  output logic     ce_n,
  output logic     si,
  input wire logic so
);
  initial
  begin
    sck = 1'b0;
    ce_n = 1'b1;
    si = 1'b0;
  end
  // one mode 0 frame, msb first; rd keeps the last eight bits seen
  task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] rd);
    #1.3 ce_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      si = d[i];
      #40 rd = {rd[6:0], so};
      sck = 1'b1;
      #40 sck = 1'b0;
    end
    si = ~si;
    #40 ce_n = 1'b1;
    #40;
  endtask
endmodule

// ### bench/fwp_flash_write_protect_regs_tb_top.sv
`timescale 1ns/1ps
module fwp_flash_write_protect_regs_tb_top;
  import fwp_pkg::*;
  logic       clk;
  logic       rstn;
  logic       wp_n;
  logic       adone;
  logic       sck;
  logic       ce_n;
  logic       si;
  logic       so;
  logic       start;
  logic       quad;
  logic [7:0] rparam;
  logic [7:0] rd;
  fwp_req_t   req;
  fwp_req_t   last_req;
  int         fails;
  int         cmp_count;
  int         n_start;
  int         n0;
  int         cyc;
  int         bk;
  logic [7:0] ops [11] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7,
                          8'h60, 8'h62, 8'h64};
  int         kd [11] = '{1, 1, 1, 2, 2, 3, 4, 5, 5, 6, 7};
  fwp_host_model host (.sck(sck), .ce_n(ce_n), .si(si), .so(so));
  fwp_flash_write_protect_regs uut (
    .REF_CLK(clk), .RSTN(rstn), .SCK(sck), .CE_N(ce_n), .SI(si), .WP_N(wp_n),
    .ARRAY_DONE(adone), .SO(so), .SO_OE(), .ARRAY_START(start), .ARRAY_SUSPEND(),
    .ARRAY_RESUME(), .ARRAY_REQ(req), .QUAD_DATA_MODE(quad), .READ_PARAM(rparam)
  );
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (start === 1'b1)
    begin
      n_start++;
      last_req = req;
    end
    if (cyc == 80000)
    begin
      fails++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
    host.xfer({op, a, 8'hA5} >> (40 - n), n, rd);
    @(posedge clk);
  endtask
  task automatic set_latch();
    cmd(8'h06, 24'h0, 8);
  endtask
  task automatic sr(input logic [7:0] e);
    cmd(8'h05, 24'h0, 16);
    chk8(e, rd);
  endtask
  task automatic fr(input logic [7:0] e);
    cmd(8'h48, 24'h0, 16);
    chk8(e, rd);
  endtask
  task automatic st(input int e);
    chk8(8'(e), 8'(n_start - n0));
    n0 = n_start;
  endtask
  task automatic fin();
    adone <= 1'b1;
    @(posedge clk);
    adone <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    wp_n = 1'b1;
    adone = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    sr(8'h00);
    fr(8'h00);
    $display("test reset done");
    set_latch();
    sr(8'h02);
    cmd(8'h04, 24'h0, 8);
    sr(8'h00);
    cmd(8'h20, 24'h010000, 32);
    st(0);
    cmd(8'hC0, 24'h550000, 16);
    chk8(8'h55, rparam);
    $display("test latch done");
    for (int i = 0; i < 11; i++)
    begin
      set_latch();
      cmd(ops[i], 24'h123456, kd[i] == 5 ? 8 : (kd[i] % 5 == 1 ? 40 : 32));
      st(1);
      chk8(8'(kd[i]), 8'(last_req.op));
      sr(8'h03);
      fin();
      sr(8'h00);
    end
    $display("test opcodes done");
    wp_n <= 1'b0;
    for (int l = 1; l < 9; l++)
    begin
      bk = l < 8 ? 128 - (1 << (l - 1)) : 0;
      set_latch();
      cmd(8'h01, {6'(l), 2'b00, 16'h0}, 16);
      sr({6'(l), 2'b00});
      set_latch();
      cmd(8'hD8, {1'b0, 7'(bk), 16'h0}, 32);
      st(0);
      sr({6'(l), 2'b10});
      if (l < 8)
      begin
        cmd(8'hD8, {1'b0, 7'(bk - 1), 16'h0}, 32);
        st(1);
        fin();
      end
    end
    cmd(8'hC7, 24'h0, 8);
    st(0);
    $display("test top levels done");
    set_latch();
    cmd(8'h42, 24'h020000, 16);
    fr(8'h02);
    set_latch();
    cmd(8'h01, 24'h0C0000, 16);
    set_latch();
    cmd(8'h20, 24'h030000, 32);
    st(0);
    cmd(8'h20, 24'h040000, 32);
    st(1);
    fin();
    set_latch();
    cmd(8'h42, 24'h0, 16);
    fr(8'h02);
    $display("test bottom done");
    set_latch();
    cmd(8'h01, 24'h800000, 16);
    set_latch();
    cmd(8'h01, 24'h400000, 16);
    sr(8'h82);
    chk8(8'h00, {7'h00, quad});
    wp_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(8'h01, 24'h400000, 16);
    sr(8'h40);
    chk8(8'h01, {7'h00, quad});
    $display("test pin lock done");
    set_latch();
    cmd(8'h42, 24'h120000, 16);
    fr(8'h12);
    set_latch();
    cmd(8'h62, 24'h0, 40);
    st(0);
    cmd(8'h62, 24'h001000, 40);
    st(1);
    fin();
    $display("test row lock done");
    for (int k = 0; k < 2; k++)
    begin
      set_latch();
      cmd(k ? 8'h20 : 8'h02, 24'h200000, k ? 32 : 40);
      st(1);
      cmd(8'h75, 24'h0, 8);
      fr(k ? 8'h1A : 8'h16);
      cmd(8'h7A, 24'h0, 8);
      fr(8'h12);
      fin();
    end
    $display("test suspend done");
    give_verdict();
  end
endmodule
